/* File: hw/adc_seq_pkg.sv */
// Register map, field positions, reset values and carrier types of the ADC sequence controller
package adc_seq_pkg;

    // Register byte addresses
    localparam logic [7:0] CONFIG_ADDR   = 8'h00;
    localparam logic [7:0] CONTROL_ADDR  = 8'h04;
    localparam logic [7:0] TEST_ADDR     = 8'h08;
    localparam logic [7:0] STATUS_ADDR   = 8'h0c;
    localparam logic [7:0] DONE_FLAGS_ADDR = 8'h10;
    localparam logic [7:0] RESULT_BASE   = 8'h20;
    localparam logic [7:0] RESULT_LAST   = 8'h3c;

    // Sequence control register fields
    localparam int CTL_JUSTIFY_RIGHT = 7;
    localparam int CTL_SIGNED        = 6;
    localparam int CTL_SCAN          = 5;
    localparam int CTL_MULTI         = 4;
    localparam int CTL_CHAN_LSB      = 0;

    // Sequence status register fields
    localparam int STAT_SEQ_DONE     = 7;
    localparam int STAT_TRIG_OVR     = 5;
    localparam int STAT_RES_OVR      = 4;
    localparam int STAT_COUNT_LSB    = 0;

    // Converter configuration register fields
    localparam int CFG_FAST_CLEAR    = 0;
    localparam int CFG_TRIG_LEVEL    = 1;
    localparam int CFG_TRIG_ENABLE   = 2;
    localparam int CFG_LOW_RES       = 3;
    localparam int CFG_FIFO          = 4;
    localparam int CFG_LEN_LSB       = 8;

    // Reset values
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [11:0] CONFIG_RESET  = 12'h000;
    localparam logic [7:0]  TEST_RESET    = 8'h00;

    // Result word bit positions
    localparam int RESULT_MSB = 15;

    // Sequence control settings, captured on every write
    typedef struct packed {
        logic       justify_right_bit;
        logic       signed_format_bit;
        logic       scan_bit;
        logic       multi_channel_bit;
        logic       unused_bit;
        logic [2:0] channel_sel;
    } seq_ctrl_s;

    // Converter configuration standing in for the other control registers
    typedef struct packed {
        logic [3:0] seq_length;
        logic [2:0] unused;
        logic       fifo_mode;
        logic       low_resolution_select;
        logic       trigger_enable;
        logic       trigger_level_select;
        logic       fast_flag_clear_enable;
    } conv_cfg_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_REQUEST,
        SEQ_WAIT
    } seq_state_e;

endpackage : adc_seq_pkg

/* File: hw/adc_sequence_control_status.sv */
// APB sequence control and status logic of an 8-channel 10-bit converter
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Control write aborts and restarts a sequence
// R2: Justify bit one right, zero left
// R3: Signed only when left justified
// R4: Result bits 8-15/6-15 left, 0-7/0-9 right
// R5: Signed equals unsigned with MSB inverted
// R6: Scan bit repeats sequences back to back
// R7: Single mode converts the selected channel
// R8: Multi mode steps channels for sequence length
// R9: Channel code maps directly, wraps at seven
// R10: Done flag set at each sequence end
// R11: Done flag cleared by one, control, fast read
// R12: Extra trigger edge while busy flags overrun
// R13: Trigger overrun cleared by one, config, control
// R14: Result overrun when unread result overwritten
// R15: Result overrun cleared by one or start
// R16: Counter shows result slot of current conversion
// R17: Counter reset at start and end unless FIFO
// R18: Status writes never touch the counter
// R19: Test register reads unpredictable, special writes
// R20: Single mode returns idle after one sequence
module adc_sequence_control_status #(
    parameter int NUM_CHANNELS = 8,
    parameter int DATA_WIDTH   = 10
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device mode and external trigger
    input  wire logic        special_mode,
    input  wire logic        ext_trigger,
    // Analog converter handshake
    output logic             conv_start,
    output logic      [2:0]  conv_channel,
    output logic             seq_busy,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_data
);

    // Elaboration checks on the fixed datapath
    if (NUM_CHANNELS != 8) begin : g_chk_ch
        $error("NUM_CHANNELS must be 8");
    end
    if (DATA_WIDTH != 10) begin : g_chk_dw
        $error("DATA_WIDTH must be 10");
    end

    adc_seq_pkg::seq_ctrl_s  ctrl_q;
    adc_seq_pkg::conv_cfg_s  cfg_q;
    adc_seq_pkg::seq_state_e state_q;
    logic [7:0]  test_q;
    logic [7:0]  noise_q;
    logic        done_flag_q;
    logic        trig_ovr_q;
    logic        res_ovr_q;
    logic [2:0]  count_q;
    logic [2:0]  chan_q;
    logic [3:0]  conv_num_q;
    logic [7:0]  ccf_q;
    logic        ccf_armed_q;
    logic [15:0] result_q [8];
    logic        trig_prev_q;

    logic        setup_acc;
    logic        done_acc;
    logic        wr;
    logic        rd;
    logic        ctrl_wr;
    logic        cfg_wr;
    logic        stat_wr;
    logic        result_rd;
    logic [2:0]  result_idx;
    logic        trig_edge;
    logic        trig_start;
    logic        trig_overrun;
    logic        start_seq;
    logic        store;
    logic [3:0]  seq_len;
    logic        last_conv;
    logic        seq_end;
    logic [15:0] fmt_word;
    logic [31:0] rd_word;
    logic        rd_err;

    // Access decode; effects land on the edge where pready is seen high
    assign setup_acc  = psel && penable && !pready;
    assign done_acc   = psel && penable && pready;
    assign wr         = done_acc && pwrite && !pslverr;
    assign rd         = done_acc && !pwrite && !pslverr;
    assign ctrl_wr    = wr && (paddr == adc_seq_pkg::CONTROL_ADDR);
    assign cfg_wr     = wr && (paddr == adc_seq_pkg::CONFIG_ADDR);
    assign stat_wr    = wr && (paddr == adc_seq_pkg::STATUS_ADDR);
    assign result_rd  = rd && (paddr >= adc_seq_pkg::RESULT_BASE) && (paddr <= adc_seq_pkg::RESULT_LAST)
                        && (paddr[1:0] == 2'b00);
    assign result_idx = paddr[4:2];

    // Edge mode flags a new edge, level mode starts while high and idle
    assign trig_edge    = cfg_q.trigger_enable && !cfg_q.trigger_level_select && ext_trigger && !trig_prev_q;
    assign trig_start   = cfg_q.trigger_enable && !ctrl_wr && !cfg_wr && (state_q == adc_seq_pkg::SEQ_IDLE)
                          && (cfg_q.trigger_level_select ? ext_trigger : trig_edge);
    assign trig_overrun = trig_edge && (state_q != adc_seq_pkg::SEQ_IDLE); // [R12]
    assign start_seq    = ctrl_wr || trig_start;

    // Length zero or above eight means a full eight conversions
    assign seq_len   = ((cfg_q.seq_length == 4'h0) || (cfg_q.seq_length > 4'h8)) ? 4'h8 : cfg_q.seq_length;
    assign store     = (state_q == adc_seq_pkg::SEQ_WAIT) && conv_done && !ctrl_wr && !cfg_wr;
    assign last_conv = (conv_num_q + 4'h1) == seq_len;
    assign seq_end   = store && last_conv;

    // Result formatting for the settings of the running sequence
    always_comb begin
        logic [7:0] low8;
        low8 = conv_data[9:2];
        if (ctrl_q.justify_right_bit) begin
            // Sign bit ignored when right justified [R3]
            fmt_word = cfg_q.low_resolution_select ? {8'h00, low8} : {6'h00, conv_data}; // [R2] [R4]
        end else begin
            fmt_word = cfg_q.low_resolution_select ? {low8, 8'h00} : {conv_data, 6'h00}; // [R2] [R4]
            if (ctrl_q.signed_format_bit) begin
                fmt_word[adc_seq_pkg::RESULT_MSB] = ~fmt_word[adc_seq_pkg::RESULT_MSB]; // [R3] [R5]
            end
        end
    end

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        unique case (paddr)
            adc_seq_pkg::CONFIG_ADDR:     rd_word = {20'h00000, cfg_q};
            adc_seq_pkg::CONTROL_ADDR:    rd_word = {24'h000000, ctrl_q};
            adc_seq_pkg::TEST_ADDR:       rd_word = {24'h000000, test_q ^ noise_q}; // [R19]
            adc_seq_pkg::STATUS_ADDR:     rd_word = {24'h000000, done_flag_q, 1'b0, trig_ovr_q, res_ovr_q,
                                                     1'b0, count_q};
            adc_seq_pkg::DONE_FLAGS_ADDR: rd_word = {24'h000000, ccf_q};
            default: begin
                if ((paddr >= adc_seq_pkg::RESULT_BASE) && (paddr <= adc_seq_pkg::RESULT_LAST)
                    && (paddr[1:0] == 2'b00)) begin
                    rd_word = {16'h0000, result_q[paddr[4:2]]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    // APB answer: one wait state, data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_acc;
            if (setup_acc) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_word;
                pslverr <= rd_err;
            end else if (done_acc) begin
                pslverr <= 1'b0;
            end
        end
    end

    // Control and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= adc_seq_pkg::CONTROL_RESET;
            cfg_q  <= adc_seq_pkg::CONFIG_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= {pwdata[7:4], 1'b0, pwdata[2:0]};
            end
            if (cfg_wr) begin
                cfg_q <= {pwdata[11:8], 3'h0, pwdata[4:0]};
            end
        end
    end

    // Test register: writable only in special mode, reads mixed with a free counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_q  <= adc_seq_pkg::TEST_RESET;
            noise_q <= 8'h00;
        end else begin
            noise_q <= noise_q + 8'h01;
            if (wr && (paddr == adc_seq_pkg::TEST_ADDR) && special_mode) begin
                test_q <= pwdata[7:0]; // [R19]
            end
        end
    end

    // Trigger input history for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= ext_trigger;
        end
    end

    // Sequencer; a control write wins over everything in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= adc_seq_pkg::SEQ_IDLE;
            conv_num_q <= 4'h0;
            chan_q     <= 3'h0;
        end else if (start_seq) begin
            state_q    <= adc_seq_pkg::SEQ_REQUEST; // [R1]
            conv_num_q <= 4'h0;
            chan_q     <= ctrl_wr ? pwdata[2:0] : ctrl_q.channel_sel; // [R7] [R9]
        end else if (cfg_wr) begin
            state_q <= adc_seq_pkg::SEQ_IDLE; // Config write aborts without restart
        end else begin
            unique case (state_q)
                adc_seq_pkg::SEQ_IDLE: begin
                    state_q <= adc_seq_pkg::SEQ_IDLE; // [R20]
                end
                adc_seq_pkg::SEQ_REQUEST: begin
                    state_q <= adc_seq_pkg::SEQ_WAIT;
                end
                adc_seq_pkg::SEQ_WAIT: begin
                    if (store) begin
                        if (last_conv) begin
                            conv_num_q <= 4'h0;
                            chan_q     <= ctrl_q.channel_sel;
                            // Scan restarts at once, single mode rests [R6] [R20]
                            state_q <= ctrl_q.scan_bit ? adc_seq_pkg::SEQ_REQUEST : adc_seq_pkg::SEQ_IDLE;
                        end else begin
                            conv_num_q <= conv_num_q + 4'h1;
                            if (ctrl_q.multi_channel_bit) begin
                                chan_q <= chan_q + 3'h1; // [R8] [R9]
                            end
                            state_q <= adc_seq_pkg::SEQ_REQUEST;
                        end
                    end
                end
            endcase
        end
    end

    // Converter handshake outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start   <= 1'b0;
            conv_channel <= 3'h0;
            seq_busy     <= 1'b0;
        end else begin
            conv_start   <= (state_q == adc_seq_pkg::SEQ_REQUEST) && !start_seq && !cfg_wr;
            conv_channel <= chan_q; // [R7] [R8]
            seq_busy     <= (state_q != adc_seq_pkg::SEQ_IDLE);
        end
    end

    // Conversion counter; status writes never reach it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 3'h0;
        end else if (start_seq && !cfg_q.fifo_mode) begin
            count_q <= 3'h0; // [R17] [R18]
        end else if (store) begin
            // Wraps naturally at seven [R16] [R17]
            count_q <= (last_conv && !cfg_q.fifo_mode) ? 3'h0 : count_q + 3'h1;
        end
    end

    // Result storage, one slot per counter value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                result_q[i] <= 16'h0000;
            end
        end else if (store) begin
            result_q[count_q] <= fmt_word; // [R16]
        end
    end

    // Per-result completion flags; set beats a read clear, control write beats set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccf_q       <= 8'h00;
            ccf_armed_q <= 1'b0;
        end else if (ctrl_wr) begin
            ccf_q       <= 8'h00;
            ccf_armed_q <= 1'b0;
        end else begin
            if (rd && (paddr == adc_seq_pkg::DONE_FLAGS_ADDR)) begin
                ccf_armed_q <= 1'b1;
            end else if (result_rd) begin
                ccf_armed_q <= 1'b0;
            end
            if (result_rd && (cfg_q.fast_flag_clear_enable || ccf_armed_q)) begin
                ccf_q[result_idx] <= 1'b0;
            end
            if (store) begin
                ccf_q[count_q] <= 1'b1;
            end
        end
    end

    // Sequence done flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_q <= 1'b0;
        end else if (ctrl_wr) begin
            done_flag_q <= 1'b0; // [R11]
        end else if (seq_end) begin
            done_flag_q <= 1'b1; // [R10]
        end else if ((stat_wr && pwdata[adc_seq_pkg::STAT_SEQ_DONE])
                     || (result_rd && cfg_q.fast_flag_clear_enable)) begin
            done_flag_q <= 1'b0; // [R11]
        end
    end

    // Trigger overrun flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_ovr_q <= 1'b0;
        end else if (ctrl_wr || cfg_wr) begin
            trig_ovr_q <= 1'b0; // [R13]
        end else if (trig_overrun) begin
            trig_ovr_q <= 1'b1; // [R12]
        end else if (stat_wr && pwdata[adc_seq_pkg::STAT_TRIG_OVR]) begin
            trig_ovr_q <= 1'b0; // [R13]
        end
    end

    // Result overrun flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_ovr_q <= 1'b0;
        end else if (start_seq) begin
            res_ovr_q <= 1'b0; // [R15]
        end else if (store && ccf_q[count_q]) begin
            res_ovr_q <= 1'b1; // [R14]
        end else if (stat_wr && pwdata[adc_seq_pkg::STAT_RES_OVR]) begin
            res_ovr_q <= 1'b0; // [R15]
        end
    end

endmodule : adc_sequence_control_status

`default_nettype wire

/* File: sim/adc_seq_asserts.sv */
// Concurrent checks on the ports of the sequence control and status block
`timescale 1ns/1ps
`default_nettype none
module adc_seq_asserts #(
    parameter int NUM_CHANNELS = 8,
    parameter int DATA_WIDTH   = 10
) (
    // APB clock, reset and slave
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Mode, trigger and converter handshake
    input wire logic        special_mode,
    input wire logic        ext_trigger,
    input wire logic        conv_start,
    input wire logic [2:0]  conv_channel,
    input wire logic        seq_busy,
    input wire logic        conv_done,
    input wire logic [9:0]  conv_data
);
    logic [2:0] last_ch_q;
    logic       wr_ctl;

    // Completed write to the sequence control register
    assign wr_ctl = psel && penable && pready && pwrite && paddr == adc_seq_pkg::CONTROL_ADDR;

    // Keep the written channel, since pwdata may move once the write is over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ch_q <= 3'h0;
        end else if (wr_ctl) begin
            last_ch_q <= pwdata[2:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("no answer after wait");
    ctl_restart_a: assert property (wr_ctl |-> ##[1:3] (conv_start && conv_channel == last_ch_q))
        else $error("control write did not restart on written channel");
    start_pulse_a: assert property (conv_start |=> !conv_start) else $error("start longer than one cycle");
    busy_start_a: assert property (conv_start |-> ##[0:1] seq_busy) else $error("start while not busy");
    done_gap_a: assert property (conv_done && seq_busy |=> !conv_start) else $error("restart too soon");
    unmapped_err_a: assert property (psel && penable && pready && paddr >= 8'h40 |-> pslverr)
        else $error("unmapped access not refused");
    status_width_a: assert property (pready && paddr == adc_seq_pkg::STATUS_ADDR |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("status read malformed");
    reset_idle_a: assert property ($rose(presetn) |-> !pready && !conv_start && !seq_busy)
        else $error("not idle after reset");

    // Main scenarios
    ctl_write_c: cover property (wr_ctl);
    conv_done_c: cover property (conv_done && seq_busy);
    refused_c: cover property (pready && pslverr);
endmodule : adc_seq_asserts

bind adc_sequence_control_status adc_seq_asserts #(.NUM_CHANNELS(NUM_CHANNELS), .DATA_WIDTH(DATA_WIDTH))
    u_adc_seq_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .ext_trigger(ext_trigger), .conv_start(conv_start),
    .conv_channel(conv_channel), .seq_busy(seq_busy), .conv_done(conv_done), .conv_data(conv_data));
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the sequence control and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, conv_start, seq_busy;
    logic        ext_trigger = 1'b0, conv_done = 1'b0;
    logic [2:0]  conv_channel;
    logic [9:0]  conv_data = 10'h3ff;
    int          n_errors = 0;
    int          compares = 0;

    // 200 MHz bus clock
    always #2.5 pclk = ~pclk;

    adc_sequence_control_status u_adc_sequence_control_status (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .special_mode(1'b0), .ext_trigger(ext_trigger), .conv_start(conv_start),
        .conv_channel(conv_channel), .seq_busy(seq_busy), .conv_done(conv_done), .conv_data(conv_data));

    task automatic results;
        $display("mismatches %0d, compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic hang(input string what);
        n_errors++;
        $display("unexpected at %0t: no %s", $time, what);
        results();
    endtask : hang

    // One APB transfer; an idle cycle after it keeps drives one per time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) hang("bus answer");
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, exp, what);
    endtask : rd

    // Answer one conversion request; poke makes a fresh trigger edge while busy
    task automatic conv(input logic [2:0] ch, input logic [9:0] d, input logic poke);
        int i;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (conv_start !== 1'b1 && i < 50);
        if (i >= 50) hang("conversion start");
        chk({29'h0, conv_channel}, {29'h0, ch}, "channel");
        @(posedge pclk);
        if (poke) ext_trigger <= 1'b0;
        @(posedge pclk);
        if (poke) ext_trigger <= 1'b1;
        @(posedge pclk);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge pclk);
        conv_done <= 1'b0;
        conv_data <= ~d;
    endtask : conv

    task automatic s_reset;
        rd(adc_seq_pkg::CONTROL_ADDR, 32'h0, "control reset");
        rd(adc_seq_pkg::STATUS_ADDR, 32'h0, "status reset");
        rd(8'h40, 32'h0, "unmapped read");
    endtask : s_reset

    // Every resolution, justification and sign combination of code 201
    task automatic s_formats;
        logic [15:0] fmt [8] = '{16'h8040, 16'h0040, 16'h0201, 16'h0201, 16'h8000, 16'h0000, 16'h0080, 16'h0080};
        for (int k = 0; k < 8; k++) begin
            wr(adc_seq_pkg::CONFIG_ADDR, 32'h100 | (32'(k[2]) << 3));
            wr(adc_seq_pkg::CONTROL_ADDR, {24'h0, k[1], k[0], 6'h05});
            conv(3'd5, 10'h201, 1'b0);
            rd(adc_seq_pkg::RESULT_BASE, {16'h0, fmt[k]}, "result format");
            rd(adc_seq_pkg::STATUS_ADDR, 32'h80, "single done");
            chk({31'h0, seq_busy}, 32'h0, "idle after one sequence");
        end
    endtask : s_formats

    task automatic s_multi;
        wr(adc_seq_pkg::CONFIG_ADDR, 32'h300);
        wr(adc_seq_pkg::CONTROL_ADDR, 32'h16);
        conv(3'd6, 10'h001, 1'b0);
        conv(3'd7, 10'h002, 1'b0);
        conv(3'd0, 10'h3ff, 1'b0);
        rd(adc_seq_pkg::RESULT_BASE + 8'h08, 32'hffc0, "third slot");
        rd(adc_seq_pkg::STATUS_ADDR, 32'h80, "multi done");
    endtask : s_multi

    // Scan overwrites an unread slot, then a control write aborts mid-conversion
    task automatic s_scan;
        wr(adc_seq_pkg::CONFIG_ADDR, 32'h100);
        wr(adc_seq_pkg::CONTROL_ADDR, 32'h23);
        conv(3'd3, 10'h001, 1'b0);
        conv(3'd3, 10'h002, 1'b0);
        rd(adc_seq_pkg::STATUS_ADDR, 32'h90, "scan overrun");
        wr(adc_seq_pkg::STATUS_ADDR, 32'ha7);
        rd(adc_seq_pkg::STATUS_ADDR, 32'h10, "done cleared");
        wr(adc_seq_pkg::CONTROL_ADDR, 32'h02);
        conv(3'd2, 10'h004, 1'b0);
        rd(adc_seq_pkg::STATUS_ADDR, 32'h80, "restart done");
    endtask : s_scan

    task automatic s_trigger;
        wr(adc_seq_pkg::CONFIG_ADDR, 32'h104);
        ext_trigger <= 1'b1;
        conv(3'd2, 10'h010, 1'b1);
        // Slot zero still held an unread result, so the store also overran it
        rd(adc_seq_pkg::STATUS_ADDR, 32'hb0, "trigger overrun");
        wr(adc_seq_pkg::CONFIG_ADDR, 32'h100);
        rd(adc_seq_pkg::STATUS_ADDR, 32'h90, "overrun cleared");
        wr(adc_seq_pkg::STATUS_ADDR, 32'h10);
        rd(adc_seq_pkg::STATUS_ADDR, 32'h80, "result overrun cleared");
        ext_trigger <= 1'b0;
    endtask : s_trigger

    // FIFO counter runs on past the sequence end; fast clear drops done on a result read
    task automatic s_fifo;
        wr(adc_seq_pkg::CONFIG_ADDR, 32'h211);
        wr(adc_seq_pkg::CONTROL_ADDR, 32'h00);
        conv(3'd0, 10'h3ff, 1'b0);
        conv(3'd0, 10'h001, 1'b0);
        rd(adc_seq_pkg::STATUS_ADDR, 32'h82, "fifo counter");
        rd(adc_seq_pkg::RESULT_BASE + 8'h04, 32'h40, "second slot");
        wr(adc_seq_pkg::STATUS_ADDR, 32'h07);
        rd(adc_seq_pkg::STATUS_ADDR, 32'h02, "fast clear");
    endtask : s_fifo

    // Reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_reset();
        s_formats();
        s_multi();
        s_scan();
        s_trigger();
        s_fifo();
        results();
    end
endmodule : testbench
`default_nettype wire
